//--- bridge_steer.v
`timescale 1ns/1ps
// turns bridge pulse, direction and float into four switch commands
module bridge_steer (
  input wire pulse_n_i,
  input wire dir_i,
  input wire float_i,
  output wire hs_a_o,
  output wire hs_b_o,
  output wire ls_a_o,
  output wire ls_b_o
);
  wire drive; // bridge pulse active and not floating

  // float wins over pulse: all four switches open
  assign drive = ~pulse_n_i & ~float_i;
  // direction high: first high side with second low side
  assign hs_a_o = drive & dir_i;
  assign ls_b_o = drive & dir_i;
  // direction low: second high side with first low side
  assign hs_b_o = drive & ~dir_i;
  assign ls_a_o = drive & ~dir_i;
endmodule // bridge_steer

//--- host_pins.sv
`timescale 1ns/1ps
// host microcontroller pins facing the pre-driver
module host_pins (
  input wire logic drive_i,
  input wire logic [7:0] on_n_cmd_i,
  input wire logic ch6_en_cmd_i,
  input wire logic off_high_cmd_i,
  input wire logic off_low_cmd_i,
  output wire logic [7:0] chan_on_n_o,
  output wire logic channel_six_enable_o,
  output wire logic ext_off_high_o,
  output wire logic ext_off_low_o
);
  // released controls read high through the pull-up, so channels stay off
  assign chan_on_n_o = drive_i ? on_n_cmd_i : 8'hFF;
  // channel six enable passes straight from the host command, even while that channel is in use
  assign channel_six_enable_o = ch6_en_cmd_i;
  // redundant disable pair of opposite sense
  assign ext_off_high_o = off_high_cmd_i;
  assign ext_off_low_o = off_low_cmd_i;
endmodule // host_pins

//--- output_channel_config_mux.v
// Contract
// - per-channel bit selects high or low side
// - per-channel fet type bit sets gate polarity
// - p type only valid on high side
// - pair a: channel 1 high, 4 low
// - pair b: channel 2 high, 3 low
// - groups force side, type stays per channel
// - bridge a: 1,2 high; 3,4 low
// - bridge b: 5,6 high; 7,8 low
// - both pairs or both bridges may coexist
// - unclaimed channels keep their own configuration
// - channel six off unless its enable high
// - either external disable switches outputs off
// - external disables never touch channels 7, 8
// - outputs follow control inputs for pwm
// - control inputs active low, idle high off
// - bridge a uses inputs 1,2,3 as pulse,dir,float
// - bridge b uses inputs 5,6,7 as pulse,dir,float
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
`include "output_channel_config_mux_regs.vh"
module output_channel_config_mux (
  input wire clk_sys_i,
  input wire resetn_i,
  // avalon-mm slave
  input wire [4:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output wire [31:0] avs_readdata_o,
  output wire avs_waitrequest_o,
  // host pins
  input wire [7:0] chan_on_n_i,
  input wire channel_six_enable_i,
  input wire ext_off_high_i,
  input wire ext_off_low_i,
  // gate driver side
  output wire [7:0] gate_on_o,
  output wire [7:0] gate_level_o,
  output wire [7:0] high_side_o,
  output wire [7:0] p_type_o,
  output wire config_error_o
);

  // merge one byte under its byte enable
  function [7:0] merge_byte;
    input [7:0] old_val;
    input [7:0] new_val;
    input lane_en;
    begin
      merge_byte = lane_en ? new_val : old_val;
    end
  endfunction

  // sticky update: set wins over write-one-to-clear
  function sticky_upd;
    input old_val;
    input set_ev;
    input clr_ev;
    begin
      sticky_upd = set_ev | (old_val & ~clr_ev);
    end
  endfunction

  // synchronised pin levels
  wire [`OCM_SYNC_W-1:0] pins_sync; // all pins after two flops
  wire [7:0] on_n_s; // control inputs, active low
  wire ch6_en_s; // channel six enable
  wire off_high_s; // disable, active high
  wire off_low_s; // disable, active low

  // configuration registers
  reg [7:0] side_select_bit_reg; // 1 = high side
  reg [7:0] fet_type_bit_reg; // 1 = p type
  reg [3:0] group_reg; // pair and bridge selects
  reg [1:0] sticky_reg; // latched events
  reg [1:0] sticky_next; // sticky next value

  // bus handshake
  reg ack_reg; // second cycle of an access
  reg [31:0] rdata_reg; // read data, valid while ack
  reg [31:0] rdata_next; // read mux result
  wire req; // any access pending
  wire wr_fire; // write takes effect this edge

  // group selects
  wire peak_hold_pair_a_select;
  wire peak_hold_pair_b_select;
  wire bridge_a_select;
  wire bridge_b_select;

  // derived configuration and commands
  reg [7:0] side_eff; // side after group forcing
  reg [7:0] cmd_on; // on command before gating
  reg [7:0] gated_on; // on command after gating
  wire [7:0] p_eff; // p type on high side only
  wire kill; // either external disable asserted
  wire cfg_err; // conflicting group selection
  wire ptype_err; // p type on a low side channel
  wire [3:0] br_a_cmd; // bridge a switch commands
  wire [3:0] br_b_cmd; // bridge b switch commands

  // registered outputs
  reg [7:0] gate_on_reg;
  reg [7:0] gate_level_reg;
  reg [7:0] high_side_reg;
  reg [7:0] p_type_reg;
  reg config_error_reg;

  // pins cross into the core clock; idle levels keep outputs off
  pin_sync2 #(
    .WIDTH(`OCM_SYNC_W),
    .RST_VAL(11'h4FF)
  ) u_pin_sync (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .async_i({ext_off_low_i, ext_off_high_i, channel_six_enable_i, chan_on_n_i}),
    .sync_o(pins_sync)
  );

  // split synchronised bundle
  assign on_n_s = pins_sync[7:0];
  assign ch6_en_s = pins_sync[8];
  assign off_high_s = pins_sync[9];
  assign off_low_s = pins_sync[10];

  // group select fields
  assign peak_hold_pair_a_select = group_reg[`OCM_PH_A_BIT];
  assign peak_hold_pair_b_select = group_reg[`OCM_PH_B_BIT];
  assign bridge_a_select = group_reg[`OCM_BR_A_BIT];
  assign bridge_b_select = group_reg[`OCM_BR_B_BIT];

  // bridge a steering from control inputs 1, 2, 3
  bridge_steer u_bridge_a (
    .pulse_n_i(on_n_s[0]),
    .dir_i(on_n_s[1]),
    .float_i(on_n_s[2]),
    .hs_a_o(br_a_cmd[0]),
    .hs_b_o(br_a_cmd[1]),
    .ls_a_o(br_a_cmd[2]),
    .ls_b_o(br_a_cmd[3])
  );

  // bridge b steering from control inputs 5, 6, 7
  bridge_steer u_bridge_b (
    .pulse_n_i(on_n_s[4]),
    .dir_i(on_n_s[5]),
    .float_i(on_n_s[6]),
    .hs_a_o(br_b_cmd[0]),
    .hs_b_o(br_b_cmd[1]),
    .ls_a_o(br_b_cmd[2]),
    .ls_b_o(br_b_cmd[3])
  );

  // effective side: own bits, then pairs, then bridges on top
  always @* begin
    side_eff = side_select_bit_reg;
    if (peak_hold_pair_a_select) begin
      side_eff[0] = 1'b1;
      side_eff[3] = 1'b0;
    end
    if (peak_hold_pair_b_select) begin
      side_eff[1] = 1'b1;
      side_eff[2] = 1'b0;
    end
    if (bridge_a_select) begin
      side_eff[1:0] = 2'h3;
      side_eff[3:2] = 2'h0;
    end
    if (bridge_b_select) begin
      side_eff[5:4] = 2'h3;
      side_eff[7:6] = 2'h0;
    end
  end

  // p type honoured only where the channel ends up high side
  assign p_eff = fet_type_bit_reg & side_eff;
  assign ptype_err = |(fet_type_bit_reg & ~side_eff);

  // bridge a overlapping a pair is a configuration error
  assign cfg_err = bridge_a_select & (peak_hold_pair_a_select | peak_hold_pair_b_select);

  // either disable pin in its active sense kills channels 1 to 6
  assign kill = off_high_s | ~off_low_s;

  // per-channel command: direct input unless a bridge owns it
  always @* begin
    cmd_on = ~on_n_s;
    if (bridge_a_select) begin
      cmd_on[3:0] = br_a_cmd;
    end
    if (bridge_b_select) begin
      cmd_on[7:4] = br_b_cmd;
    end
  end

  // safety gating of the commands
  always @* begin
    gated_on = cmd_on;
    if (kill) begin
      gated_on[5:0] = 6'h00;
    end
    if (!ch6_en_s) begin
      gated_on[5] = 1'b0;
    end
  end

  // outputs from flops: one core cycle after the synchronisers
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      gate_on_reg <= 8'h00;
      gate_level_reg <= 8'h00;
      high_side_reg <= 8'h00;
      p_type_reg <= 8'h00;
      config_error_reg <= 1'b0;
    end else begin
      gate_on_reg <= gated_on;
      // p type conducts with gate low, n type with gate high
      gate_level_reg <= gated_on ^ p_eff;
      high_side_reg <= side_eff;
      p_type_reg <= p_eff;
      config_error_reg <= cfg_err | ptype_err;
    end
  end

  assign gate_on_o = gate_on_reg;
  assign gate_level_o = gate_level_reg;
  assign high_side_o = high_side_reg;
  assign p_type_o = p_type_reg;
  assign config_error_o = config_error_reg;

  // bus: wait one cycle, answer in the second
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_reg;
  assign wr_fire = avs_write_i & ack_reg;
  assign avs_readdata_o = rdata_reg;

  // ack toggles high for one cycle per access
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
    end
  end

  // read mux; unmapped addresses read zero
  always @* begin
    rdata_next = 32'h00000000;
    case (avs_address_i)
      `OCM_SIDE_OFS: begin
        rdata_next[7:0] = side_select_bit_reg;
      end
      `OCM_TYPE_OFS: begin
        rdata_next[7:0] = fet_type_bit_reg;
      end
      `OCM_GROUP_OFS: begin
        rdata_next[3:0] = group_reg;
      end
      `OCM_STATUS_OFS: begin
        rdata_next[`OCM_ST_CFG_ERR_BIT] = cfg_err;
        rdata_next[`OCM_ST_KILL_BIT] = kill;
        rdata_next[`OCM_ST_CH6_EN_BIT] = ch6_en_s;
        rdata_next[`OCM_ST_PTYPE_ERR_BIT] = ptype_err;
        rdata_next[`OCM_ST_ON_LSB +: 8] = gate_on_reg;
        rdata_next[`OCM_ST_SIDE_LSB +: 8] = high_side_reg;
        rdata_next[`OCM_ST_GATE_LSB +: 8] = gate_level_reg;
      end
      `OCM_PINS_OFS: begin
        rdata_next[7:0] = on_n_s;
        rdata_next[`OCM_PIN_OFF_HIGH_BIT] = off_high_s;
        rdata_next[`OCM_PIN_OFF_LOW_BIT] = off_low_s;
        rdata_next[`OCM_PIN_CH6_EN_BIT] = ch6_en_s;
      end
      `OCM_STICKY_OFS: begin
        rdata_next[1:0] = sticky_reg;
      end
      default: begin
        rdata_next = 32'h00000000;
      end
    endcase
  end

  // read data captured in the wait cycle, stands in the ack cycle
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_reg <= 32'h00000000;
    end else if (avs_read_i && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  // configuration writes, byte lane 0 only carries data
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      side_select_bit_reg <= `OCM_SIDE_RST;
      fet_type_bit_reg <= `OCM_TYPE_RST;
      group_reg <= `OCM_GROUP_RST;
    end else if (wr_fire) begin
      case (avs_address_i)
        `OCM_SIDE_OFS: begin
          side_select_bit_reg <= merge_byte(side_select_bit_reg, avs_writedata_i[7:0], avs_byteenable_i[0]);
        end
        `OCM_TYPE_OFS: begin
          fet_type_bit_reg <= merge_byte(fet_type_bit_reg, avs_writedata_i[7:0], avs_byteenable_i[0]);
        end
        `OCM_GROUP_OFS: begin
          if (avs_byteenable_i[0]) begin
            group_reg <= avs_writedata_i[3:0];
          end
        end
        default: begin
          group_reg <= group_reg;
        end
      endcase
    end
  end

  // sticky events: kill seen, configuration error seen
  always @* begin
    sticky_next[`OCM_SK_KILL_BIT] = sticky_upd(sticky_reg[`OCM_SK_KILL_BIT], kill,
      wr_fire && avs_address_i == `OCM_STICKY_OFS && avs_byteenable_i[0] &&
      avs_writedata_i[`OCM_SK_KILL_BIT]);
    sticky_next[`OCM_SK_CFG_BIT] = sticky_upd(sticky_reg[`OCM_SK_CFG_BIT], cfg_err | ptype_err,
      wr_fire && avs_address_i == `OCM_STICKY_OFS && avs_byteenable_i[0] &&
      avs_writedata_i[`OCM_SK_CFG_BIT]);
  end

  // sticky register update
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sticky_reg <= `OCM_STICKY_RST;
    end else begin
      sticky_reg <= sticky_next;
    end
  end

endmodule // output_channel_config_mux

//--- output_channel_config_mux_asserts.sv
`timescale 1ns/1ps
// port-level checker for the channel mux
module ocm_checker (
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic avs_write_i,
  input wire logic [7:0] chan_on_n_i,
  input wire logic channel_six_enable_i,
  input wire logic ext_off_high_i,
  input wire logic ext_off_low_i,
  input wire logic [7:0] gate_on_o,
  input wire logic [7:0] gate_level_o,
  input wire logic [7:0] high_side_o,
  input wire logic [7:0] p_type_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // high disable held past sync and output stages
  property p_off_high;
    ext_off_high_i [*4] |-> gate_on_o[5:0] == 6'h00;
  endproperty
  a_off_high: assert property (p_off_high) else $error("high disable left a channel on");
  // low disable held past sync and output stages
  property p_off_low;
    (!ext_off_low_i) [*4] |-> gate_on_o[5:0] == 6'h00;
  endproperty
  a_off_low: assert property (p_off_low) else $error("low disable left a channel on");
  // channel six needs its enable
  property p_ch6_en;
    (!channel_six_enable_i) [*4] |-> !gate_on_o[5];
  endproperty
  a_ch6_en: assert property (p_ch6_en) else $error("channel six on without enable");
  // idle controls keep every channel off
  property p_idle;
    (chan_on_n_i == 8'hFF) [*4] |-> gate_on_o == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("channel on with idle controls");
  // gate polarity follows the effective type
  property p_level;
    gate_level_o == (gate_on_o ^ p_type_o);
  endproperty
  a_level: assert property (p_level) else $error("gate level polarity wrong");
  // p type only ever on a high side
  property p_ptype_hs;
    (p_type_o & ~high_side_o) == 8'h00;
  endproperty
  a_ptype_hs: assert property (p_ptype_hs) else $error("p type on low side");
  // channels seven and eight ignore the disables
  property p_keep78;
    ($stable(chan_on_n_i) && !avs_write_i) [*4] |-> $stable(gate_on_o[7:6]);
  endproperty
  a_keep78: assert property (p_keep78) else $error("channel seven or eight moved");
  // a falling control shows at the output after sync and output stages
  property p_follow;
    (chan_on_n_i == 8'hFF) [*4] ##1 (chan_on_n_i == 8'h00) [*4] |-> gate_on_o[7:6] != 2'b00;
  endproperty
  a_follow: assert property (p_follow) else $error("output missed control edge");
  cover property (ext_off_high_i [*4]);
  cover property (gate_on_o == 8'h69);
  cover property ((!channel_six_enable_i) [*4]);
endmodule // ocm_checker
bind output_channel_config_mux ocm_checker i_chk (.clk_sys_i, .resetn_i, .avs_write_i, .chan_on_n_i,
  .channel_six_enable_i, .ext_off_high_i, .ext_off_low_i, .gate_on_o, .gate_level_o, .high_side_o, .p_type_o);

//--- output_channel_config_mux_regs.vh
`ifndef OUTPUT_CHANNEL_CONFIG_MUX_REGS_VH
`define OUTPUT_CHANNEL_CONFIG_MUX_REGS_VH

// register byte offsets
`define OCM_SIDE_OFS 5'h00
`define OCM_TYPE_OFS 5'h04
`define OCM_GROUP_OFS 5'h08
`define OCM_STATUS_OFS 5'h0C
`define OCM_PINS_OFS 5'h10
`define OCM_STICKY_OFS 5'h14

// reset values
`define OCM_SIDE_RST 8'h00
`define OCM_TYPE_RST 8'h00
`define OCM_GROUP_RST 4'h0
`define OCM_STICKY_RST 2'h0

// group register fields
`define OCM_PH_A_BIT 0
`define OCM_PH_B_BIT 1
`define OCM_BR_A_BIT 2
`define OCM_BR_B_BIT 3

// status register fields
`define OCM_ST_CFG_ERR_BIT 0
`define OCM_ST_KILL_BIT 1
`define OCM_ST_CH6_EN_BIT 2
`define OCM_ST_PTYPE_ERR_BIT 3
`define OCM_ST_ON_LSB 8
`define OCM_ST_SIDE_LSB 16
`define OCM_ST_GATE_LSB 24

// pin register fields
`define OCM_PIN_OFF_HIGH_BIT 8
`define OCM_PIN_OFF_LOW_BIT 9
`define OCM_PIN_CH6_EN_BIT 10

// sticky register fields
`define OCM_SK_KILL_BIT 0
`define OCM_SK_CFG_BIT 1

// synchroniser width, one bit per synchronised pin
`define OCM_SYNC_W 11

`endif

//--- output_channel_config_mux_test.sv
`timescale 1ns/1ps
`include "output_channel_config_mux_regs.vh"
module output_channel_config_mux_test;
  logic clk_sys_i = 1'b0; // core clock
  logic resetn_i = 1'b0; // reset, active low
  logic [4:0] avs_address_i = 5'h00; // bus request
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  wire [31:0] avs_readdata_o;
  wire avs_waitrequest_o;
  logic drv = 1'b0; // host pin commands
  logic [7:0] on_n_cmd = 8'hFF;
  logic ch6_en_cmd = 1'b0;
  logic off_high_cmd = 1'b0;
  logic off_low_cmd = 1'b1;
  wire [7:0] chan_on_n_i, gate_on_o, gate_level_o, high_side_o, p_type_o;
  wire channel_six_enable_i, ext_off_high_i, ext_off_low_i, config_error_o;
  logic [31:0] rd; // last read data
  int errors = 0;
  int n_checks = 0;
  // clock, 25 ns period
  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end
  host_pins i_host (.drive_i(drv), .on_n_cmd_i(on_n_cmd), .ch6_en_cmd_i(ch6_en_cmd), .off_high_cmd_i(off_high_cmd),
    .off_low_cmd_i(off_low_cmd), .chan_on_n_o(chan_on_n_i), .channel_six_enable_o(channel_six_enable_i),
    .ext_off_high_o(ext_off_high_i), .ext_off_low_o(ext_off_low_i));
  output_channel_config_mux i_dut (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .chan_on_n_i(chan_on_n_i), .channel_six_enable_i(channel_six_enable_i), .ext_off_high_i(ext_off_high_i),
    .ext_off_low_i(ext_off_low_i), .gate_on_o(gate_on_o), .gate_level_o(gate_level_o),
    .high_side_o(high_side_o), .p_type_o(p_type_o), .config_error_o(config_error_o));
  // verdict and end of run
  task complete_run;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // compare seen against expected
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one bus access, held until the rising edge that sees waitrequest low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    avs_writedata_i <= d;
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask
  // side, type and group set, then outputs settle
  task cfg(input logic [7:0] s, input logic [7:0] t, input logic [7:0] g);
    bus(1'b1, `OCM_SIDE_OFS, {24'h000000, s});
    bus(1'b1, `OCM_TYPE_OFS, {24'h000000, t});
    bus(1'b1, `OCM_GROUP_OFS, {24'h000000, g});
    repeat (2) @(posedge clk_sys_i);
    #1;
  endtask
  // host pins change, then sync and output stages pass
  task pins(input logic [7:0] c, input logic d, input logic e6, input logic oh, input logic ol);
    @(posedge clk_sys_i);
    on_n_cmd <= c;
    drv <= d;
    ch6_en_cmd <= e6;
    off_high_cmd <= oh;
    off_low_cmd <= ol;
    repeat (4) @(posedge clk_sys_i);
    #1;
  endtask
  // reset values and an unmapped read
  task t_regs;
    bus(1'b0, `OCM_SIDE_OFS, 32'h00000000);
    check(rd[7:0], 8'h00);
    bus(1'b0, `OCM_GROUP_OFS, 32'h00000000);
    check(rd[7:0], 8'h00);
    bus(1'b0, 5'h18, 32'h00000000);
    check(rd[7:0], 8'h00);
  endtask
  // plain side and type settings
  task t_side;
    cfg(8'hFF, 8'h10, 8'h00);
    pins(8'h00, 1'b1, 1'b1, 1'b0, 1'b1);
    check(gate_on_o, 8'hFF);
    check(high_side_o, 8'hFF);
    check(gate_level_o, 8'hEF);
    cfg(8'h0F, 8'h10, 8'h00);
    check(p_type_o, 8'h00);
    check({7'h00, config_error_o}, 8'h01);
    pins(8'h00, 1'b0, 1'b1, 1'b0, 1'b1);
    check(gate_on_o, 8'h00);
  endtask
  // both pairs, free channels keep own side
  task t_pairs;
    cfg(8'hF0, 8'h00, 8'h03);
    check(high_side_o, 8'hF3);
    check({7'h00, config_error_o}, 8'h00);
    cfg(8'h00, 8'h00, 8'h05);
    check(high_side_o, 8'h03);
    check({7'h00, config_error_o}, 8'h01);
  endtask
  // both bridges, direction, float and channel six enable
  task t_bridges;
    cfg(8'h00, 8'h01, 8'h0C);
    check(high_side_o, 8'h33);
    pins(8'h8A, 1'b1, 1'b1, 1'b0, 1'b1);
    check(gate_on_o, 8'h69);
    check(gate_level_o, 8'h68);
    pins(8'h8A, 1'b1, 1'b0, 1'b0, 1'b1);
    check(gate_on_o, 8'h49);
    pins(8'hA8, 1'b1, 1'b1, 1'b0, 1'b1);
    check(gate_on_o, 8'h96);
    pins(8'hCE, 1'b1, 1'b1, 1'b0, 1'b1);
    check(gate_on_o, 8'h00);
  endtask
  // each disable alone, seven and eight unaffected
  task t_disable;
    cfg(8'hFF, 8'h00, 8'h00);
    pins(8'h00, 1'b1, 1'b1, 1'b1, 1'b1);
    check(gate_on_o, 8'hC0);
    pins(8'h00, 1'b1, 1'b1, 1'b0, 1'b0);
    check(gate_on_o, 8'hC0);
    pins(8'h00, 1'b1, 1'b1, 1'b0, 1'b1);
    check(gate_on_o, 8'hFF);
    // kill and configuration error both latched earlier, then cleared
    bus(1'b0, `OCM_STICKY_OFS, 32'h00000000);
    check(rd[7:0], 8'h03);
    bus(1'b1, `OCM_STICKY_OFS, 32'h00000003);
    bus(1'b0, `OCM_STICKY_OFS, 32'h00000000);
    check(rd[7:0], 8'h00);
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    t_regs;
    t_side;
    t_pairs;
    t_bridges;
    t_disable;
    complete_run;
  end
  // watchdog against a hung handshake
  initial begin
    repeat (4000) @(posedge clk_sys_i);
    errors++;
    complete_run;
  end
endmodule // output_channel_config_mux_test

//--- pin_sync2.v
`timescale 1ns/1ps
// two flip-flop synchroniser for asynchronous pin levels
module pin_sync2 #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VAL = {WIDTH{1'b0}}
) (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_reg; // first stage, read only by second
  reg [WIDTH-1:0] stable_reg; // second stage, safe to use

  // both stages reset to the idle pin level
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_reg <= RST_VAL;
      stable_reg <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      stable_reg <= meta_reg;
    end
  end

  assign sync_o = stable_reg;
endmodule // pin_sync2
